// *** rtl/cwd_pkg.sv ***
// constants and types shared by the configuration word decoder
package cwd_pkg;
  // ==========================================================
  // word zero field layout
  localparam int unsigned PROTECT_LSB = 10;
  localparam int unsigned PROTECT_W = 9;
  localparam int unsigned PAIR_LSB = 3;
  localparam int unsigned SCAN_BIT = 2;
  localparam int unsigned DEBUG_LSB = 0;
  localparam logic [31:0] ZERO_RSVD_MASK = 32'h0000_03e0;
  // ==========================================================
  // word one field layout
  localparam int unsigned WINSZ_LSB = 24;
  localparam int unsigned WDT_FIXED_BIT = 23;
  localparam int unsigned WIN_DIS_BIT = 22;
  localparam int unsigned PSCALE_LSB = 16;
  localparam int unsigned PSCALE_W = 5;
  localparam int unsigned PBDIV_LSB = 12;
  localparam int unsigned POSC_MODE_LSB = 8;
  localparam int unsigned OSC_SEL_LSB = 0;
  localparam logic [31:0] ONE_RSVD_MASK = 32'hfc20_0858;
  // ==========================================================
  // decode constants
  localparam int unsigned PAGE_SHIFT = 10;
  localparam int unsigned LIMIT_W = 20;
  localparam logic [4:0] PSCALE_MAX = 5'h14;
  localparam int unsigned RATIO_W = 21;
  localparam logic [1:0] DEBUG_OFF = 2'h3;
  localparam logic [1:0] POSC_OFF = 2'h3;
  // open window in eighths of the period
  localparam logic [3:0] WIN_25 = 4'h2;
  localparam logic [3:0] WIN_37 = 4'h3;
  localparam logic [3:0] WIN_50 = 4'h4;
  localparam logic [3:0] WIN_75 = 4'h6;
  // ==========================================================
  // register map, byte addresses
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_WORD_ZERO = 4'h0;
  localparam logic [3:0] OFS_WORD_ONE = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // control register bits
  localparam int unsigned CTL_SCAN_BIT = 0;
  localparam int unsigned CTL_WDT_SW_BIT = 1;
  // status register bits
  localparam int unsigned ST_LOADED = 0;
  localparam int unsigned ST_WDT_RUN = 1;
  localparam int unsigned ST_DEBUG_EN = 2;
  localparam int unsigned ST_PROTECT = 3;
  localparam int unsigned ST_RSVD_FAULT = 4;
  localparam int unsigned ST_OSC_CONFLICT = 5;
  localparam int unsigned ST_CODE_PROT = 6;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CWD_SYNC0 = 2'b00,
    CWD_SYNC1 = 2'b01,
    CWD_CAPT = 2'b10,
    CWD_HOLD = 2'b11
  } cwd_load_t;
  typedef enum logic [2:0] {
    CWD_OSC_FRC = 3'b000,
    CWD_OSC_FRC_PLL = 3'b001,
    CWD_OSC_PRI = 3'b010,
    CWD_OSC_PRI_PLL = 3'b011,
    CWD_OSC_SEC = 3'b100,
    CWD_OSC_LPRC = 3'b101,
    CWD_OSC_FRC_DIV16 = 3'b110,
    CWD_OSC_FRC_DIVN = 3'b111
  } cwd_osc_t;
endpackage

// *** rtl/cwd_flash_protect.sv ***
// flash write-protect boundary decoder with registered limit
`timescale 1ns/1ns
module cwd_flash_protect #(
  parameter bit FLASH_256K = 1'b1,
  parameter int unsigned FLASH_BYTES = 32'h0004_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [cwd_pkg::PROTECT_W-1:0] code,
  output logic [cwd_pkg::LIMIT_W-1:0] limit,
  output logic active
);
  localparam logic [cwd_pkg::LIMIT_W-1:0] FLASH_TOP = FLASH_BYTES[cwd_pkg::LIMIT_W-1:0];
  if (FLASH_BYTES == 0 || FLASH_BYTES >= (1 << cwd_pkg::LIMIT_W)) begin : g_chk
    $error("flash size does not fit the limit width");
  end
  logic [cwd_pkg::LIMIT_W-1:0] limit_reg, limit_next;

  // code to boundary: each step below all ones adds one page
  function automatic logic [cwd_pkg::LIMIT_W-1:0] to_limit(input logic [8:0] raw);
    logic [8:0] c;
    logic [cwd_pkg::LIMIT_W-1:0] l;
    c = FLASH_256K ? raw : {2'h3, raw[6:0]};
    l = cwd_pkg::LIMIT_W'({~c}) << cwd_pkg::PAGE_SHIFT; // pages to bytes
    if (&c) begin
      l = '0;
    end else if (raw == 9'h000 || l > FLASH_TOP) begin
      l = FLASH_TOP;
    end
    return l;
  endfunction

  // next limit, captured once at load
  always_comb begin
    limit_next = limit_reg;
    if (load) begin
      limit_next = to_limit(code);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      limit_reg <= '0;
    end else if (ce) begin
      limit_reg <= limit_next;
    end
  end
  assign limit = limit_reg;
  assign active = (limit_reg != '0);

  // ==========================================================
  // checks
  AST_PROT_OFF: assert property (@(posedge clk) disable iff (rst)
    ce && load && (&code) |=> limit == '0) else $error("all ones must disable protect");
  AST_PROT_ALL: assert property (@(posedge clk) disable iff (rst)
    ce && load && code == 9'h000 |=> limit == FLASH_TOP) else $error("zero code must cover all");
  AST_PROT_PAGE: assert property (@(posedge clk) disable iff (rst)
    ce && load && code == 9'h1f7 |=> limit == 20'h02000) else $error("code 1f7 boundary wrong");
  AST_PROT_HIGH: assert property (@(posedge clk) disable iff (rst)
    ce && load && code == 9'h0ff && FLASH_256K && FLASH_BYTES >= 32'h40000
    |=> limit == 20'h40000) else $error("code 0ff boundary wrong");
endmodule

// *** rtl/cwd_wdt_decode.sv ***
// watchdog configuration field decoder with registered outputs
`timescale 1ns/1ns
module cwd_wdt_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [1:0] win_size,
  input wire logic win_dis,
  input wire logic fixed_en,
  input wire logic [cwd_pkg::PSCALE_W-1:0] pscale,
  output logic [3:0] window_eighths,
  output logic window_mode,
  output logic fixed_enable,
  output logic [cwd_pkg::PSCALE_W-1:0] pscale_shift,
  output logic [cwd_pkg::RATIO_W-1:0] pscale_ratio
);
  logic [3:0] win_reg, win_next;
  logic mode_reg, mode_next;
  logic fixed_reg, fixed_next;
  logic [cwd_pkg::PSCALE_W-1:0] shift_reg, shift_next;

  // window size code to open eighths
  function automatic logic [3:0] to_window(input logic [1:0] c);
    unique case (c)
      2'b11: return cwd_pkg::WIN_25;
      2'b10: return cwd_pkg::WIN_37;
      2'b01: return cwd_pkg::WIN_50;
      2'b00: return cwd_pkg::WIN_75;
    endcase
  endfunction

  // next values, taken only at load
  always_comb begin
    win_next = win_reg;
    mode_next = mode_reg;
    fixed_next = fixed_reg;
    shift_next = shift_reg;
    if (load) begin
      win_next = to_window(win_size);
      mode_next = ~win_dis;
      fixed_next = fixed_en;
      shift_next = (pscale > cwd_pkg::PSCALE_MAX) ? cwd_pkg::PSCALE_MAX : pscale;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_reg <= cwd_pkg::WIN_75;
      mode_reg <= 1'b0;
      fixed_reg <= 1'b0;
      shift_reg <= '0;
    end else if (ce) begin
      win_reg <= win_next;
      mode_reg <= mode_next;
      fixed_reg <= fixed_next;
      shift_reg <= shift_next;
    end
  end
  assign window_eighths = win_reg;
  assign window_mode = mode_reg;
  assign fixed_enable = fixed_reg;
  assign pscale_shift = shift_reg;
  assign pscale_ratio = cwd_pkg::RATIO_W'(1) << shift_reg;

  // ==========================================================
  // checks
  AST_WIN_SIZE: assert property (@(posedge clk) disable iff (rst)
    ce && load && win_size == 2'b10 |=> window_eighths == 4'h3) else $error("window 37.5 wrong");
  AST_WIN_MODE: assert property (@(posedge clk) disable iff (rst)
    ce && load |=> window_mode == !$past(win_dis)) else $error("window mode wrong");
  AST_PS_CLAMP: assert property (@(posedge clk) disable iff (rst)
    ce && load && pscale > 5'h14 |=> pscale_ratio == 21'h100000) else $error("postscale clamp");
  AST_PS_RATIO: assert property (@(posedge clk) disable iff (rst)
    ce && load && pscale == 5'h00 |=> pscale_ratio == 21'h000001) else $error("postscale 1:1");
endmodule

// *** rtl/cwd_config_word_decoder.sv ***
// configuration word decoder top: capture, decode, control registers
//
// Contract
// - all-ones protect code disables write protection
// - protect codes step boundary one 1 KB page
// - codes 1bf, 17f, 0ff protect 64K/128K/256K
// - all-zero protect code covers all flash
// - top protect bits only on 256 KB parts
// - pair select 11..00 picks pairs one..four
// - word bit 2 loads runtime scan enable
// - debugger off when upper bit set; protect forces
// - window size codes give 25 to 75 percent
// - fixed watchdog enable runs, software cannot stop
// - window disable bit selects non-window mode
// - postscale ratio is two to the code
// - postscale codes above 10100 act as 10100
// - oscillator select picks one of eight sources
// - peripheral divisor codes 00..11 give 1,2,4,8
`timescale 1ns/1ns
module cwd_config_word_decoder #(
  parameter bit FLASH_256K = 1'b1,
  parameter int unsigned FLASH_BYTES = 32'h0004_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] config_word_zero,
  input wire logic [31:0] config_word_one,
  input wire logic code_protect,
  input wire logic [cwd_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic loaded,
  output logic [cwd_pkg::LIMIT_W-1:0] flash_protect_boundary,
  output logic flash_protect_active,
  output logic [3:0] emulator_pair_select,
  output logic scan_port_enable,
  output logic [1:0] debug_field,
  output logic debugger_enable,
  output logic watchdog_run,
  output logic watchdog_fixed_enable,
  output logic watchdog_window_mode,
  output logic [3:0] watchdog_window_size,
  output logic [cwd_pkg::PSCALE_W-1:0] watchdog_postscale,
  output logic [cwd_pkg::RATIO_W-1:0] watchdog_postscale_ratio,
  output cwd_pkg::cwd_osc_t osc_source_select,
  output logic [1:0] primary_osc_mode,
  output logic [3:0] periph_clock_divisor,
  output logic reserved_fault,
  output logic osc_conflict
);
  // ==========================================================
  // pin synchronisers, two stages each
  logic [31:0] zero_meta_reg, zero_sync_reg;
  logic [31:0] one_meta_reg, one_sync_reg;
  logic cp_meta_reg, cp_sync_reg;

  // words are static pins; both stages only register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_meta_reg <= '0;
      zero_sync_reg <= '0;
      one_meta_reg <= '0;
      one_sync_reg <= '0;
      cp_meta_reg <= 1'b0;
      cp_sync_reg <= 1'b0;
    end else if (ce) begin
      zero_meta_reg <= config_word_zero;
      zero_sync_reg <= zero_meta_reg;
      one_meta_reg <= config_word_one;
      one_sync_reg <= one_meta_reg;
      cp_meta_reg <= code_protect;
      cp_sync_reg <= cp_meta_reg;
    end
  end

  // ==========================================================
  // capture sequence and held words
  cwd_pkg::cwd_load_t state_reg, state_next;
  logic [31:0] zero_reg, zero_next;
  logic [31:0] one_reg, one_next;
  logic cp_reg, cp_next;
  logic capture;

  // walk past the synchroniser, capture once, then hold
  always_comb begin
    state_next = state_reg;
    zero_next = zero_reg;
    one_next = one_reg;
    cp_next = cp_reg;
    capture = 1'b0;
    unique case (state_reg)
      cwd_pkg::CWD_SYNC0: state_next = cwd_pkg::CWD_SYNC1;
      cwd_pkg::CWD_SYNC1: state_next = cwd_pkg::CWD_CAPT;
      cwd_pkg::CWD_CAPT: begin
        capture = 1'b1;
        zero_next = zero_sync_reg;
        one_next = one_sync_reg;
        cp_next = cp_sync_reg;
        state_next = cwd_pkg::CWD_HOLD;
      end
      cwd_pkg::CWD_HOLD: state_next = cwd_pkg::CWD_HOLD;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= cwd_pkg::CWD_SYNC0;
      zero_reg <= '0;
      one_reg <= '0;
      cp_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      zero_reg <= zero_next;
      one_reg <= one_next;
      cp_reg <= cp_next;
    end
  end
  assign loaded = (state_reg == cwd_pkg::CWD_HOLD);

  // ==========================================================
  // field decoders
  cwd_flash_protect #(
    .FLASH_256K(FLASH_256K),
    .FLASH_BYTES(FLASH_BYTES)
  ) u_protect (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(capture),
    .code(zero_sync_reg[cwd_pkg::PROTECT_LSB +: cwd_pkg::PROTECT_W]),
    .limit(flash_protect_boundary),
    .active(flash_protect_active)
  );
  cwd_wdt_decode u_wdt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(capture),
    .win_size(one_sync_reg[cwd_pkg::WINSZ_LSB +: 2]),
    .win_dis(one_sync_reg[cwd_pkg::WIN_DIS_BIT]),
    .fixed_en(one_sync_reg[cwd_pkg::WDT_FIXED_BIT]),
    .pscale(one_sync_reg[cwd_pkg::PSCALE_LSB +: cwd_pkg::PSCALE_W]),
    .window_eighths(watchdog_window_size),
    .window_mode(watchdog_window_mode),
    .fixed_enable(watchdog_fixed_enable),
    .pscale_shift(watchdog_postscale),
    .pscale_ratio(watchdog_postscale_ratio)
  );

  // ==========================================================
  // small decodes of the held words
  function automatic logic [3:0] pair_onehot(input logic [1:0] c);
    unique case (c)
      2'b11: return 4'h1;
      2'b10: return 4'h2;
      2'b01: return 4'h4;
      2'b00: return 4'h8;
    endcase
  endfunction

  logic [1:0] dbg_eff;
  logic [2:0] osc_code;
  logic [1:0] posc_code;
  always_comb begin
    dbg_eff = cp_reg ? cwd_pkg::DEBUG_OFF : zero_reg[cwd_pkg::DEBUG_LSB +: 2];
    osc_code = one_reg[cwd_pkg::OSC_SEL_LSB +: 3];
    posc_code = one_reg[cwd_pkg::POSC_MODE_LSB +: 2];
  end

  // decoded outputs as flops
  logic [3:0] pair_reg, pair_next;
  logic [1:0] dbg_reg, dbg_next;
  cwd_pkg::cwd_osc_t osc_reg, osc_next;
  logic [1:0] posc_reg, posc_next;
  logic [3:0] pbdiv_reg, pbdiv_next;
  logic rsvd_reg, rsvd_next;
  logic conflict_reg, conflict_next;
  always_comb begin
    pair_next = pair_onehot(zero_reg[cwd_pkg::PAIR_LSB +: 2]);
    dbg_next = dbg_eff;
    osc_next = cwd_pkg::cwd_osc_t'(osc_code);
    posc_next = posc_code;
    pbdiv_next = 4'h1 << one_reg[cwd_pkg::PBDIV_LSB +: 2];
    // programmer left a reserved bit at zero
    rsvd_next = loaded && (((zero_reg & cwd_pkg::ZERO_RSVD_MASK) != cwd_pkg::ZERO_RSVD_MASK)
      || ((one_reg & cwd_pkg::ONE_RSVD_MASK) != cwd_pkg::ONE_RSVD_MASK));
    // primary source chosen while primary oscillator is off
    conflict_next = loaded && (osc_code == cwd_pkg::CWD_OSC_PRI
      || osc_code == cwd_pkg::CWD_OSC_PRI_PLL) && posc_code == cwd_pkg::POSC_OFF;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pair_reg <= 4'h1;
      dbg_reg <= cwd_pkg::DEBUG_OFF;
      osc_reg <= cwd_pkg::CWD_OSC_FRC;
      posc_reg <= cwd_pkg::POSC_OFF;
      pbdiv_reg <= 4'h1;
      rsvd_reg <= 1'b0;
      conflict_reg <= 1'b0;
    end else if (ce) begin
      pair_reg <= pair_next;
      dbg_reg <= dbg_next;
      osc_reg <= osc_next;
      posc_reg <= posc_next;
      pbdiv_reg <= pbdiv_next;
      rsvd_reg <= rsvd_next;
      conflict_reg <= conflict_next;
    end
  end
  assign emulator_pair_select = pair_reg;
  assign debug_field = dbg_reg;
  assign debugger_enable = ~dbg_reg[1];
  assign osc_source_select = osc_reg;
  assign primary_osc_mode = posc_reg;
  assign periph_clock_divisor = pbdiv_reg;
  assign reserved_fault = rsvd_reg;
  assign osc_conflict = conflict_reg;

  // ==========================================================
  // runtime control register: scan enable, software watchdog enable
  logic scan_reg, scan_next;
  logic wdt_sw_reg, wdt_sw_next;
  logic ctl_hit;
  always_comb begin
    scan_next = scan_reg;
    wdt_sw_next = wdt_sw_reg;
    ctl_hit = bus_wr && bus_addr == cwd_pkg::OFS_CONTROL;
    if (capture) begin
      scan_next = zero_sync_reg[cwd_pkg::SCAN_BIT];
      wdt_sw_next = 1'b0;
    end else if (ctl_hit && loaded) begin
      scan_next = bus_wdata[cwd_pkg::CTL_SCAN_BIT];
      wdt_sw_next = bus_wdata[cwd_pkg::CTL_WDT_SW_BIT];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_reg <= 1'b0;
      wdt_sw_reg <= 1'b0;
    end else if (ce) begin
      scan_reg <= scan_next;
      wdt_sw_reg <= wdt_sw_next;
    end
  end
  assign scan_port_enable = scan_reg;
  assign watchdog_run = watchdog_fixed_enable | wdt_sw_reg;

  // ==========================================================
  // register read port, data one cycle after the strobe
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[cwd_pkg::ST_LOADED] = loaded;
    status_word[cwd_pkg::ST_WDT_RUN] = watchdog_run;
    status_word[cwd_pkg::ST_DEBUG_EN] = debugger_enable;
    status_word[cwd_pkg::ST_PROTECT] = flash_protect_active;
    status_word[cwd_pkg::ST_RSVD_FAULT] = reserved_fault;
    status_word[cwd_pkg::ST_OSC_CONFLICT] = osc_conflict;
    status_word[cwd_pkg::ST_CODE_PROT] = cp_reg;
    rdata_next = '0;
    if (bus_rd) begin
      unique case (bus_addr)
        cwd_pkg::OFS_WORD_ZERO: rdata_next = zero_reg;
        cwd_pkg::OFS_WORD_ONE: rdata_next = one_reg;
        cwd_pkg::OFS_CONTROL: rdata_next = {30'h0, wdt_sw_reg, scan_reg};
        cwd_pkg::OFS_STATUS: rdata_next = status_word;
        default: rdata_next = '0; // unmapped reads zero
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end
  assign bus_rdata = rdata_reg;

  // ==========================================================
  // checks
  AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (rst)
    loaded |=> loaded && $stable(zero_reg) && $stable(one_reg)) else $error("words changed");
  AST_CAPT_ONCE: assert property (@(posedge clk) disable iff (rst)
    ce && state_reg == cwd_pkg::CWD_CAPT |=> zero_reg == $past(zero_sync_reg) ##1 loaded)
    else $error("capture missed");
  AST_SCAN_INIT: assert property (@(posedge clk) disable iff (rst)
    ce && capture |=> scan_port_enable == $past(zero_sync_reg[2])) else $error("scan init");
  AST_DEBUG_FORCE: assert property (@(posedge clk) disable iff (rst)
    ce && loaded && cp_reg |=> debug_field == 2'b11 && !debugger_enable)
    else $error("protect must force debugger off");
  AST_DEBUG_EN: assert property (@(posedge clk) disable iff (rst)
    ce && loaded && !cp_reg && !zero_reg[1] |=> debugger_enable) else $error("debugger off");
  AST_PAIR_FOUR: assert property (@(posedge clk) disable iff (rst)
    ce && loaded && zero_reg[4:3] == 2'b00 |=> emulator_pair_select == 4'h8)
    else $error("pair four not chosen");
  AST_WDT_FIXED: assert property (@(posedge clk) disable iff (rst)
    loaded && watchdog_fixed_enable |-> watchdog_run) else $error("fixed watchdog stopped");
  AST_PBDIV: assert property (@(posedge clk) disable iff (rst)
    ce && loaded && one_reg[13:12] == 2'b11 |=> periph_clock_divisor == 4'h8)
    else $error("divisor eight wrong");
  AST_OSC_SEL: assert property (@(posedge clk) disable iff (rst)
    ce && loaded |=> osc_source_select == $past(one_reg[2:0])) else $error("osc select wrong");
  AST_OSC_CONFLICT: assert property (@(posedge clk) disable iff (rst)
    ce && loaded && one_reg[2:1] == 2'b01 && one_reg[9:8] == 2'b11 |=> osc_conflict)
    else $error("conflict not flagged");
  AST_RD_LATENCY: assert property (@(posedge clk) disable iff (rst)
    ce && bus_rd && bus_addr == cwd_pkg::OFS_WORD_ONE |=> bus_rdata == $past(one_reg))
    else $error("read data wrong");
  COV_LOADED: cover property (@(posedge clk) disable iff (rst) $rose(loaded));
  COV_SW_WDT: cover property (@(posedge clk) disable iff (rst)
    loaded && !watchdog_fixed_enable ##1 watchdog_run);
  COV_PROTECT: cover property (@(posedge clk) disable iff (rst) loaded && cp_reg);
endmodule

// *** test/cwd_config_word_decoder_tb_top.sv ***
// self-checking testbench for the configuration word decoder
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module cwd_config_word_decoder_tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cp = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [31:0] w0 = 32'h0, w1 = 32'h0, wdata = 32'h0, rdata;
  logic [3:0] addr = 4'h0, pair, wsz, pdiv;
  logic [19:0] bound;
  logic [1:0] dbg, posc;
  logic [4:0] psc;
  logic [20:0] ratio;
  logic loaded, pact, scan, dbg_en, run, fixed, wmode, rfault, oconf;
  cwd_pkg::cwd_osc_t osc;
  int err_total = 0, checks_done = 0;
  logic [8:0] pcode [8] = '{9'h1ff, 9'h1fe, 9'h1f7, 9'h1ef, 9'h1bf, 9'h17f, 9'h0ff, 9'h000};
  logic [19:0] pbnd [8] = '{20'h0, 20'h00400, 20'h02000, 20'h04000, 20'h10000, 20'h20000,
    20'h40000, 20'h40000};
  logic [4:0] ps [8] = '{5'h00, 5'h01, 5'h0a, 5'h13, 5'h14, 5'h15, 5'h1e, 5'h1f};
  logic [3:0] ws [4] = '{4'h6, 4'h4, 4'h3, 4'h2};
  always #5 clk = ~clk;
  cwd_config_word_decoder DUT (.clk(clk), .rst(rst), .ce(ce), .config_word_zero(w0),
    .config_word_one(w1), .code_protect(cp), .bus_addr(addr), .bus_wdata(wdata),
    .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata), .loaded(loaded),
    .flash_protect_boundary(bound), .flash_protect_active(pact),
    .emulator_pair_select(pair), .scan_port_enable(scan), .debug_field(dbg),
    .debugger_enable(dbg_en), .watchdog_run(run), .watchdog_fixed_enable(fixed),
    .watchdog_window_mode(wmode), .watchdog_window_size(wsz), .watchdog_postscale(psc),
    .watchdog_postscale_ratio(ratio), .osc_source_select(osc), .primary_osc_mode(posc),
    .periph_clock_divisor(pdiv), .reserved_fault(rfault), .osc_conflict(oconf));
  // ==========================================================
  // shared tasks: load words through reset, bus write and read
  task automatic ld(input logic [31:0] a, input logic [31:0] b, input logic c);
    @(posedge clk);
    rst <= 1'b1;
    w0 <= a;
    w1 <= b;
    cp <= c;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // ==========================================================
  // eight sets of field codes decoded, each after a fresh capture
  task automatic t_decode;
    logic [31:0] a, b, d, st;
    logic [4:0] pe;
    logic [1:0] k, pm;
    logic c;
    for (int i = 0; i < 8; i++) begin
      k = i[1:0];
      c = i[2];
      pm = (i == 2) ? 2'h3 : 2'h1;
      pe = (ps[i] > 5'h14) ? 5'h14 : ps[i];
      a = 32'h0000_03e0 | (32'(pcode[i]) << 10) | (32'(k) << 3) | (32'(i[0]) << 2) | 32'(k);
      b = 32'hfc20_0858 | (32'(k) << 24) | (32'(i[0]) << 23) | (32'(i[1]) << 22) |
        (32'(ps[i]) << 16) | (32'(k) << 12) | (32'(pm) << 8) | 32'(i[2:0]);
      if (i == 7) b[21] = 1'b0;
      ld(a, b, c);
      `CHK(loaded, 1'b1)
      `CHK(bound, pbnd[i])
      `CHK(pact, (pbnd[i] != 20'h0))
      `CHK(pair, 4'h1 << (2'h3 - k))
      `CHK(scan, i[0])
      `CHK(dbg, c ? 2'h3 : k)
      `CHK(dbg_en, c ? 1'b0 : ~k[1])
      `CHK(fixed, i[0])
      `CHK(run, i[0])
      `CHK(wmode, ~i[1])
      `CHK(wsz, ws[k])
      `CHK(psc, pe)
      `CHK(ratio, 21'h1 << pe)
      `CHK(osc, cwd_pkg::cwd_osc_t'(i[2:0]))
      `CHK(posc, pm)
      `CHK(pdiv, 4'h1 << k)
      `CHK(oconf, (i == 2))
      `CHK(rfault, (i == 7))
      // status word: code protect, conflict, fault, protect, debugger, run, loaded
      st = {25'h0, c, (i == 2), (i == 7), (pbnd[i] != 20'h0), ~(k[1] | c), i[0], 1'b1};
      bus_read(4'hc, d);
      `CHK(d, st)
    end
    $display("test decode done");
  endtask
  // ==========================================================
  // register access, runtime control and holding of captured words
  task automatic t_bus;
    logic [31:0] d;
    ld(32'h0007_fbe0, 32'hfc20_0858, 1'b0);
    @(posedge clk);
    w0 <= 32'h0;
    repeat (3) @(posedge clk);
    bus_read(4'h0, d);
    `CHK(d, 32'h0007_fbe0)
    `CHK(bound, 20'h00400)
    bus_read(4'h4, d);
    `CHK(d, 32'hfc20_0858)
    bus_read(4'h2, d);
    `CHK(d, 32'h0)
    bus_write(4'h0, 32'h0);
    bus_read(4'h0, d);
    `CHK(d, 32'h0007_fbe0)
    bus_write(4'h8, 32'h3);
    `CHK(scan, 1'b1)
    `CHK(run, 1'b1)
    bus_read(4'h8, d);
    `CHK(d, 32'h3)
    bus_read(4'hc, d);
    `CHK(d, 32'h0000_000f)
    @(posedge clk);
    #1;
    `CHK(rdata, 32'h0)
    bus_write(4'h8, 32'h0);
    `CHK(scan, 1'b0)
    `CHK(run, 1'b0)
    ld(32'h0007_fbe0, 32'hfca0_0858, 1'b0);
    bus_write(4'h8, 32'h0);
    `CHK(run, 1'b1)
    bus_read(4'h8, d);
    `CHK(d, 32'h0)
    // clock enable low freezes the control register
    @(posedge clk);
    ce <= 1'b0;
    bus_write(4'h8, 32'h1);
    `CHK(scan, 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    bus_write(4'h8, 32'h1);
    `CHK(scan, 1'b1)
    $display("test bus done");
  endtask
  // ==========================================================
  // verdict and run control
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    t_decode();
    t_bus();
    wrap_up();
  end
endmodule
